// [common/lgpc_regs.vh]
// Purpose: Register offsets, field widths and reset values for the LED/GPIO pin control block
// Assumes: 8-bit register port, byte offsets
// Notes:   Definitions only
`ifndef LGPC_REGS_VH
`define LGPC_REGS_VH

// ======================================================================
// Register offsets
`define LGPC_ADDR_DIR        8'h70
`define LGPC_ADDR_OTYPE      8'h71
`define LGPC_ADDR_INLVL      8'h72
`define LGPC_ADDR_ACT_LO     8'h73
`define LGPC_ADDR_ACT_HI     8'h74
`define LGPC_ADDR_POL_LO     8'h75
`define LGPC_ADDR_POL_HI     8'h76
`define LGPC_ADDR_CHG_STS    8'h78
`define LGPC_ADDR_CHG_MASK   8'h79

// ======================================================================
// Field layout
`define LGPC_NGPIO           8
`define LGPC_NLED            11
`define LGPC_HI_BITS         3
`define LGPC_LED8_IDX        7
`define LGPC_LED9_IDX        8
`define LGPC_LED10_IDX       9
`define LGPC_LED11_IDX       10

// ======================================================================
// Reset values
`define LGPC_RST_BYTE        8'h00
`define LGPC_RST_HI          3'h0
`define LGPC_RST_LED         11'h000
`define LGPC_RST_OEN         11'h7ff
`define LGPC_RST_FILL        3'h0

// ======================================================================
// Timing counts
`define LGPC_SYNC_FILL       3'h4

`endif

// [dv/lgpc_pin_ctrl_assertions.sv]
// Purpose: Port checks for the pin control block
// Assumes: Shadows follow register writes on the same edge as the block
// Notes:   Drive checks lag one sample behind registers and links
`timescale 1ns/1ps
`default_nettype none
module lgpc_pin_ctrl_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [7:0]  pin_in,
    input wire logic [10:0] led_pin_out,
    input wire logic [10:0] led_pin_oe_n,
    input wire logic [10:0] led_touch_link,
    input wire logic        led10_group_linked,
    input wire logic        group_touch,
    input wire logic        irq
);
    // ======================================
    // Shadow registers
    logic [7:0]  dir_r, typ_r, alo_r, plo_r, msk_r;
    logic [2:0]  ahi_r, phi_r;
    logic [10:0] eff, lg;
    logic [7:0]  oe_lo, out_lo;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {dir_r, typ_r, alo_r, plo_r, msk_r, ahi_r, phi_r} <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                8'h70: dir_r <= reg_wdata;
                8'h71: typ_r <= reg_wdata;
                8'h73: alo_r <= reg_wdata;
                8'h74: ahi_r <= reg_wdata[2:0];
                8'h75: plo_r <= reg_wdata;
                8'h76: phi_r <= reg_wdata[2:0];
                8'h79: msk_r <= reg_wdata;
                default: ;
            endcase
        end
    end
    // LED8 and LED11 take no link; the group drives LED9 and LED10
    assign eff = {ahi_r, alo_r} | {1'b0, led_touch_link[9:8] |
                 {2{led10_group_linked & group_touch}}, 1'b0, led_touch_link[6:0]};
    assign lg = ~(eff ^ {phi_r, plo_r});
    assign oe_lo = ~dir_r | (~typ_r & lg[7:0]);
    assign out_lo = dir_r & typ_r & lg[7:0];
    // ======================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_settled; $stable(pin_in)[*8]; endsequence
    sequence s_lvl_read; reg_rd && reg_addr == 8'h72; endsequence
    a_lo_enable: assert property (led_pin_oe_n[7:0] == $past(oe_lo))
        else $error("low pin enable wrong");
    a_lo_drive: assert property (led_pin_out[7:0] == $past(out_lo))
        else $error("low pin drive wrong");
    a_hi_sink: assert property (led_pin_out[10:8] == 3'h0)
        else $error("high pin drives high");
    a_hi_enable: assert property (led_pin_oe_n[10:8] == $past(lg[10:8]))
        else $error("high pin enable wrong");
    a_led11_solo: assert property ($past(led_touch_link[10] && !ahi_r[2] && !phi_r[2])
        |-> led_pin_oe_n[10]) else $error("LED11 followed a link");
    a_irq_masked: assert property (irq |-> msk_r != 8'h00)
        else $error("irq with all masked");
    a_level_settles: assert property (s_settled ##0 s_lvl_read |=>
        reg_rdata == $past(pin_in)) else $error("input level stale");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h70 || reg_addr > 8'h79 ||
        reg_addr == 8'h77) |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule // lgpc_pin_ctrl_chk
`default_nettype wire

// [dv/lgpc_pin_ctrl_tb.sv]
// Purpose: Register and pin tests for the pin control block
// Assumes: Pins 5-8 driven from outside, 1-4 left to the block
// Notes:   Expected pin levels worked out by hand per test
`timescale 1ns/1ps
`default_nettype none
module lgpc_pin_ctrl_tb;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, led10_group_linked = 0, group_touch = 0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pin_in;
    logic [7:0]  ext_lvl = 8'h00, ext_en = 8'hf0;
    logic [10:0] led_pin_out, led_pin_oe_n, led_touch_link = 11'h000;
    logic        irq;
    logic [7:0]  ra [4] = '{8'h70, 8'h71, 8'h73, 8'h74};
    int          num_errors = 0, tests_run = 0;
    always #5 clk = ~clk;
    lgpc_pin_ctrl uut (.*);
    lgpc_pin_model u_pins (.drv_out(led_pin_out[7:0]), .drv_oe_n(led_pin_oe_n[7:0]),
        .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_lvl(pin_in));
    // ======================================
    // Access tasks
    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", {3'h0, e}, {3'h0, reg_rdata});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("tests_run %0d num_errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ======================================
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], 8'h00);
        rd(8'h72, 8'h0f);
        wr(8'h74, 8'hff);
        rd(8'h74, 8'h07);
        wr(8'h72, 8'h55);
        rd(8'h72, 8'h0f);
        rd(8'h7f, 8'h00);
        wr(8'h74, 8'h00);
        $display("test regs done");
        wr(8'h70, 8'h0f);
        wr(8'h71, 8'h03);
        wr(8'h73, 8'h05);
        tick(2);
        chk("led_pin_out", 11'h002, led_pin_out);
        chk("led_pin_oe_n", 11'h7f8, led_pin_oe_n);
        wr(8'h75, 8'h0f);
        tick(2);
        chk("led_pin_out", 11'h001, led_pin_out);
        chk("led_pin_oe_n", 11'h7f4, led_pin_oe_n);
        @(posedge clk);
        led_touch_link <= 11'h700;
        tick(2);
        chk("led_pin_oe_n", 11'h4f4, led_pin_oe_n);
        @(posedge clk);
        led_touch_link <= 11'h000;
        led10_group_linked <= 1'b1;
        group_touch <= 1'b1;
        tick(2);
        chk("led_pin_oe_n", 11'h4f4, led_pin_oe_n);
        $display("test drive done");
        wr(8'h79, 8'hff);
        rd(8'h78, 8'h00);
        chk("irq", 11'h000, {10'h000, irq});
        @(posedge clk);
        ext_lvl <= 8'h10;
        tick(6);
        chk("irq", 11'h001, {10'h000, irq});
        rd(8'h72, 8'h15);
        rd(8'h78, 8'h10);
        chk("irq", 11'h000, {10'h000, irq});
        wr(8'h79, 8'h00);
        @(posedge clk);
        ext_lvl <= 8'h30;
        tick(6);
        chk("irq", 11'h000, {10'h000, irq});
        rd(8'h78, 8'h20);
        $display("test input done");
        results();
    end
    initial begin
        #20000;
        num_errors++;
        results();
    end
endmodule // lgpc_pin_ctrl_tb
bind lgpc_pin_ctrl lgpc_pin_ctrl_chk u_chk (.*);
`default_nettype wire

// [dv/lgpc_pin_model.sv]
// Purpose: Shared pin wires with outside sources and pull-ups
// Assumes: Outside sources only drive where enabled
// Notes:   Contention is not modelled
`timescale 1ns/1ps
`default_nettype none
module lgpc_pin_model (
    input wire logic [7:0] drv_out,
    input wire logic [7:0] drv_oe_n,
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] ext_en,
    output logic [7:0]     pin_lvl
);
    // ======================================
    // Released and undriven pins float up
    assign pin_lvl = (~drv_oe_n & drv_out) | (drv_oe_n & (~ext_en | ext_lvl));
endmodule // lgpc_pin_model
`default_nettype wire

// [hdl/lgpc_pin_ctrl.v]
// Purpose: Per-pin direction, output type, actuation and change detection for LED/GPIO pins
// Assumes: One clock; pins arrive asynchronously; PWM and linking logic sit elsewhere
// Notes:   Pin drive is static: minimum duty is taken as fully off, maximum as fully on
//          Change flags are sticky, cleared by reading them; a same-edge change survives
//          Pin levels need four clocks to appear; pulses spanning fewer than two clock edges are missed
//          LED9-11 have no type bit and always sink as open-drain
//          Touch links arrive as levels already combined by the outside logic
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lgpc_regs.vh"

module lgpc_pin_ctrl (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire [7:0]  pin_in,
    output reg  [10:0] led_pin_out,
    output reg  [10:0] led_pin_oe_n,
    input  wire [10:0] led_touch_link,
    input  wire        led10_group_linked,
    input  wire        group_touch,
    output wire        irq
);

    // ==================================================================
    // Register map, byte offsets
    //   DIR      rw  direction, set bit drives
    //   OTYPE    rw  output type, set bit push-pull
    //   INLVL    ro  synchronised pin levels
    //   ACT_LO   rw  actuation LED1-8
    //   ACT_HI   rw  actuation LED9-11 in bits 2-0
    //   POL_LO   rw  polarity LED1-8, set is non-inverted
    //   POL_HI   rw  polarity LED9-11 in bits 2-0
    //   CHG_STS  rc  change flags, a read clears them
    //   CHG_MASK rw  change interrupt enables
    //   Every register resets to zero
    //   Any other offset reads zero and ignores writes

    // ==================================================================
    // Register state
    reg [7:0]  pin_direction_r;
    reg [7:0]  pin_output_type_r;
    reg [10:0] led_actuation_r;
    reg [10:0] led_polarity_r;
    reg [7:0]  pin_change_flag_r;
    reg [7:0]  chg_mask_r;
    reg [7:0]  rdata_nxt;

    // ==================================================================
    // Helper functions
    // Kept as functions so the write decode and read mux cannot drift apart
    // Address match shared by the write decode and the read mux
    function lgpc_hit;
        input [7:0] addr;
        input [7:0] offs;
        begin
            lgpc_hit = (addr == offs);
        end
    endfunction

    // Upper LED byte carries three live bits; the rest read zero
    function [7:0] lgpc_pad_hi;
        input [2:0] bits;
        begin
            lgpc_pad_hi = {5'h00, bits};
        end
    endfunction

    // Upper LED byte keeps only its three live bits on a write
    function [2:0] lgpc_cut_hi;
        input [7:0] data;
        begin
            lgpc_cut_hi = data[2:0];
        end
    endfunction

    // Sticky flag update: a new event beats the clearing read
    function [7:0] lgpc_flag_nxt;
        input [7:0] flags;
        input [7:0] evt;
        input       clr;
        begin
            if (clr) begin
                lgpc_flag_nxt = evt;
            end else begin
                lgpc_flag_nxt = flags | evt;
            end
        end
    endfunction

    // Pin drive from logic level, returned as {drive value, enable low}
    // Open-drain only ever sinks, so its drive value stays low
    function [1:0] lgpc_pin_drive;
        input is_out;
        input push_pull;
        input lvl;
        begin
            if (!is_out) begin
                lgpc_pin_drive = 2'b01;
            end else if (push_pull) begin
                lgpc_pin_drive = {lvl, 1'b0};
            end else begin
                lgpc_pin_drive = {1'b0, lvl};
            end
        end
    endfunction

    // ==================================================================
    // Pin input synchroniser and change detect
    reg [7:0]  sync1_r;
    reg [7:0]  sync2_r;
    reg [7:0]  sync3_r;
    reg [7:0]  pin_input_level_r;
    wire [7:0] agree;
    wire [7:0] lvl_nxt;
    wire [7:0] change_evt;

    // Level moves only once stages two and three agree, filtering a single metastable sample
    assign agree      = ~(sync2_r ^ sync3_r);
    assign lvl_nxt    = (agree & sync3_r) | (~agree & pin_input_level_r);

    // Stages fill from reset zeros and idle-high pins would look like a change,
    // so no flag is raised until the fill is over; a real change that early is lost
    reg  [2:0] fill_cnt_r;
    wire       primed;
    assign primed     = (fill_cnt_r == `LGPC_SYNC_FILL);
    assign change_evt = (lvl_nxt ^ pin_input_level_r) & ~pin_direction_r & {8{primed}};

    // Three-stage synchroniser; only stage two reads stage one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= `LGPC_RST_BYTE;
            sync2_r <= `LGPC_RST_BYTE;
            sync3_r <= `LGPC_RST_BYTE;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Level follows the pin whatever the pin's direction
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_input_level_r <= `LGPC_RST_BYTE;
        end else begin
            pin_input_level_r <= lvl_nxt;
        end
    end

    // Counts the edges that carry the first real sample through every stage
    // Saturates, so the gate opens once and stays open until the next reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_cnt_r <= `LGPC_RST_FILL;
        end else if (!primed) begin
            fill_cnt_r <= fill_cnt_r + 3'h1;
        end
    end

    // ==================================================================
    // Register writes
    // Writes land at the strobe edge and read back on the next request
    // Writes to the input level and status offsets decode to nothing
    wire wr_dir  = reg_wr && lgpc_hit(reg_addr, `LGPC_ADDR_DIR);
    wire wr_ot   = reg_wr && lgpc_hit(reg_addr, `LGPC_ADDR_OTYPE);
    wire wr_alo  = reg_wr && lgpc_hit(reg_addr, `LGPC_ADDR_ACT_LO);
    wire wr_ahi  = reg_wr && lgpc_hit(reg_addr, `LGPC_ADDR_ACT_HI);
    wire wr_plo  = reg_wr && lgpc_hit(reg_addr, `LGPC_ADDR_POL_LO);
    wire wr_phi  = reg_wr && lgpc_hit(reg_addr, `LGPC_ADDR_POL_HI);
    wire wr_msk  = reg_wr && lgpc_hit(reg_addr, `LGPC_ADDR_CHG_MASK);
    wire rd_sts  = reg_rd && lgpc_hit(reg_addr, `LGPC_ADDR_CHG_STS);

    // Direction, cleared at reset so no LED1-8 pin drives before software asks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_direction_r <= `LGPC_RST_BYTE;
        end else if (wr_dir) begin
            pin_direction_r <= reg_wdata;
        end
    end

    // Output type, only consulted for output pins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_output_type_r <= `LGPC_RST_BYTE;
        end else if (wr_ot) begin
            pin_output_type_r <= reg_wdata;
        end
    end

    // Actuation LED1-8
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_actuation_r[7:0] <= `LGPC_RST_BYTE;
        end else if (wr_alo) begin
            led_actuation_r[7:0] <= reg_wdata;
        end
    end

    // Actuation LED9-11
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_actuation_r[10:8] <= `LGPC_RST_HI;
        end else if (wr_ahi) begin
            led_actuation_r[10:8] <= lgpc_cut_hi(reg_wdata);
        end
    end

    // Polarity LED1-8
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_polarity_r[7:0] <= `LGPC_RST_BYTE;
        end else if (wr_plo) begin
            led_polarity_r[7:0] <= reg_wdata;
        end
    end

    // Polarity LED9-11
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_polarity_r[10:8] <= `LGPC_RST_HI;
        end else if (wr_phi) begin
            led_polarity_r[10:8] <= lgpc_cut_hi(reg_wdata);
        end
    end

    // Change interrupt enables
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_mask_r <= `LGPC_RST_BYTE;
        end else if (wr_msk) begin
            chg_mask_r <= reg_wdata;
        end
    end

    // Sticky change flags; a change in the same cycle as the clearing read survives
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_change_flag_r <= `LGPC_RST_BYTE;
        end else begin
            pin_change_flag_r <= lgpc_flag_nxt(pin_change_flag_r, change_evt, rd_sts);
        end
    end

    // ==================================================================
    // Interrupt, a level while any enabled flag stands
    assign irq = |(pin_change_flag_r & chg_mask_r);

    // ==================================================================
    // Read port, data one cycle after the strobe
    always @* begin
        rdata_nxt = `LGPC_RST_BYTE;
        // Unmapped offsets fall through to zero
        if (!reg_rd) begin
            rdata_nxt = `LGPC_RST_BYTE;
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_DIR)) begin
            rdata_nxt = pin_direction_r;
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_OTYPE)) begin
            rdata_nxt = pin_output_type_r;
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_INLVL)) begin
            rdata_nxt = pin_input_level_r;
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_ACT_LO)) begin
            rdata_nxt = led_actuation_r[7:0];
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_ACT_HI)) begin
            rdata_nxt = lgpc_pad_hi(led_actuation_r[10:8]);
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_POL_LO)) begin
            rdata_nxt = led_polarity_r[7:0];
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_POL_HI)) begin
            rdata_nxt = lgpc_pad_hi(led_polarity_r[10:8]);
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_CHG_STS)) begin
            rdata_nxt = pin_change_flag_r;
        end else if (lgpc_hit(reg_addr, `LGPC_ADDR_CHG_MASK)) begin
            rdata_nxt = chg_mask_r;
        end
    end

    // Zero outside the answer cycle, so a stale value is never mistaken for data
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `LGPC_RST_BYTE;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ==================================================================
    // Effective actuation and pin drive
    // Touches from the outside linking logic merge into the actuation bits.
    // Duty-cycle shaping is not modelled: an actuated pin sits fully on and
    // a non-actuated pin fully off, so minimum duty reads as off.
    // Pins leave through flip-flops so a decode glitch never reaches a pad.
    // The cost is one clock of lag after any register or link change.
    // LED8 and LED11 are stripped of links here rather than trusted to the source.
    reg [10:0] link_mask;
    reg [10:0] act_eff;
    reg [10:0] logic_lvl;
    reg [10:0] out_nxt;
    reg [10:0] oen_nxt;
    integer    i;

    always @* begin
        link_mask                  = led_touch_link;
        link_mask[`LGPC_LED8_IDX]  = 1'b0;
        link_mask[`LGPC_LED11_IDX] = 1'b0;
        if (led10_group_linked) begin
            link_mask[`LGPC_LED10_IDX] = link_mask[`LGPC_LED10_IDX] | group_touch;
            link_mask[`LGPC_LED9_IDX]  = link_mask[`LGPC_LED9_IDX] | group_touch;
        end
    end

    // Per-pin drive from effective actuation, polarity, direction and type
    always @* begin
        act_eff   = led_actuation_r | link_mask;
        // Clear polarity inverts: actuated is logic 0; inactive is logic 1
        logic_lvl = ~(act_eff ^ led_polarity_r);
        for (i = 0; i < `LGPC_NLED; i = i + 1) begin
            out_nxt[i] = 1'b0;
            oen_nxt[i] = 1'b1;
            if (i >= `LGPC_NGPIO) begin
                // LED9-11 have no direction or type bit: always open-drain sinks
                {out_nxt[i], oen_nxt[i]} = lgpc_pin_drive(1'b1, 1'b0, logic_lvl[i]);
            end else begin
                // LED1-8 follow their direction bit, then their type bit
                {out_nxt[i], oen_nxt[i]} = lgpc_pin_drive(pin_direction_r[i],
                                                          pin_output_type_r[i],
                                                          logic_lvl[i]);
            end
        end
    end

    // Drive value, low at reset so an early enable cannot source current
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_pin_out <= `LGPC_RST_LED;
        end else begin
            led_pin_out <= out_nxt;
        end
    end

    // Enables, all released at reset; LED1-8 until software picks a direction, LED9-11 until their logic level goes low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_pin_oe_n <= `LGPC_RST_OEN;
        end else begin
            led_pin_oe_n <= oen_nxt;
        end
    end

endmodule // lgpc_pin_ctrl
`default_nettype wire
